// ### logic/rim_monitor.sv
// remote interface monitor: access control, message timeout, link supervision
`default_nettype none
// What this block does
// - front port reads of values and status are always answered
// - front port writes rejected while master or another interface holds control
// - front port accepts both text and framed protocols, reduced command subset only
// - rear port grants the full command set, master operation only on a non-slave unit
// - only the interface holding remote control is supervised
// - a slave unit keeps its host-interface monitor inactive
// - master-slave link loss raises the master-slave protection alarm
// - no message within the programmed period declares a timeout
// - each message on the supervised interface restarts the period
// - on timeout the device leaves remote control
// - on timeout with output on, output follows the after-remote setting
// - a new timeout value applies only after the running period elapses or the monitor goes inactive
// - network connection timeout runs independently alongside the monitor
// - remote request refused with error during master-slave; master init of USB-held slave refused
module rim_monitor #(
   parameter int TICK_CYC = rim_pkg::RIM_TICK_CYC
) (
   input  wire logic                          i_mclk,
   input  wire logic                          i_rst_b,
   // configuration, same clock domain
   input  wire logic                          i_mon_enable,
   input  wire logic [rim_pkg::RIM_TMO_W-1:0] i_mon_timeout,
   input  wire logic [rim_pkg::RIM_TMO_W-1:0] i_net_timeout,
   input  wire logic                          i_keep_on_after_remote,
   input  wire logic                          i_is_slave,
   input  wire logic                          i_ms_running,
   // remote control requests, one-cycle pulses
   input  wire logic                          i_req_valid,
   input  wire rim_pkg::rim_owner_t           i_req_src,
   input  wire logic                          i_release,
   // message strobes per interface
   input  wire logic                          i_msg_rear,
   input  wire logic                          i_msg_front,
   input  wire logic                          i_msg_net,
   input  wire logic                          i_msg_master,
   // front and rear command classification
   input  wire logic                          i_front_cmd,
   input  wire logic                          i_front_is_write,
   input  wire logic                          i_front_in_subset,
   input  wire logic                          i_rear_cmd,
   input  wire logic                          i_rear_is_master,
   // master-slave link health, from pins
   input  wire logic                          i_ms_link_ok,
   input  wire logic                          i_ms_heartbeat,
   input  wire logic                          i_alarm_ack,
   // dc output state from the power stage
   input  wire logic                          i_dc_on,
   output logic                               o_remote,
   output rim_pkg::rim_owner_t                o_owner,
   output logic                               o_req_error,
   output logic                               o_front_accept,
   output logic                               o_front_reject,
   output logic                               o_rear_accept,
   output logic                               o_timeout,
   output logic                               o_dc_off_req,
   output logic                               o_net_timeout,
   output logic                               o_msp_alarm
);
   localparam int TW = rim_pkg::RIM_TMO_W;

   rim_pkg::rim_owner_t owner_r;
   logic [TW-1:0] cnt_r;
   logic [TW-1:0] period_r;
   logic [TW-1:0] net_cnt_r;
   logic [TW-1:0] ms_cnt_r;
   logic [rim_pkg::RIM_TICK_W-1:0] div_r;
   logic tick;
   logic mon_active;
   logic sup_msg;
   logic expire;
   logic link_s1_r, link_s2_r, hb_s1_r, hb_s2_r, hb_d_r;
   logic net_up_r;

   // tick divider; all timeouts count in ticks
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         div_r <= '0;
      end else if (div_r == rim_pkg::RIM_TICK_W'(TICK_CYC - 1)) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end
   assign tick = (div_r == rim_pkg::RIM_TICK_W'(TICK_CYC - 1));

   // message strobe of the owner only; other interfaces are ignored
   always_comb begin
      case (owner_r)
         rim_pkg::RIM_OWN_REAR:   sup_msg = i_msg_rear;
         rim_pkg::RIM_OWN_FRONT:  sup_msg = i_msg_front;
         rim_pkg::RIM_OWN_NET:    sup_msg = i_msg_net;
         default:                 sup_msg = 1'b0;
      endcase
   end

   // slave units and master-owned or analog control are never host-monitored
   assign mon_active = i_mon_enable && !i_is_slave && (owner_r == rim_pkg::RIM_OWN_REAR
                       || owner_r == rim_pkg::RIM_OWN_FRONT
                       || owner_r == rim_pkg::RIM_OWN_NET);
   assign expire = mon_active && tick && !sup_msg && (cnt_r + 1'b1 >= period_r)
                   && (period_r != rim_pkg::RIM_TMO_ZERO);

   // monitor counter; the period is latched while the monitor is inactive and on expiry, not on a message restart
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_r    <= '0;
         period_r <= '0;
      end else if (!mon_active) begin
         cnt_r    <= '0;
         period_r <= i_mon_timeout;
      end else if (sup_msg) begin
         cnt_r    <= '0;
      end else if (expire) begin
         cnt_r    <= '0;
         period_r <= i_mon_timeout;
      end else if (tick) begin
         cnt_r    <= cnt_r + 1'b1;
      end
   end

   // ownership: one owner at a time; master-slave excludes user interfaces
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         owner_r     <= rim_pkg::RIM_OWN_NONE;
         o_req_error <= 1'b0;
      end else begin
         o_req_error <= 1'b0;
         if (expire) begin
            owner_r <= rim_pkg::RIM_OWN_NONE;
         end else if (i_release) begin
            owner_r <= rim_pkg::RIM_OWN_NONE;
         end else if (i_req_valid) begin
            if (i_req_src == rim_pkg::RIM_OWN_MASTER) begin
               if (owner_r == rim_pkg::RIM_OWN_REAR || owner_r == rim_pkg::RIM_OWN_FRONT) begin
                  o_req_error <= 1'b1;         // usb holds control
               end else begin
                  owner_r <= rim_pkg::RIM_OWN_MASTER;
               end
            end else if (i_ms_running || owner_r == rim_pkg::RIM_OWN_MASTER) begin
               o_req_error <= 1'b1;
            end else if (owner_r == rim_pkg::RIM_OWN_NONE || owner_r == i_req_src) begin
               owner_r <= i_req_src;
            end else begin
               o_req_error <= 1'b1;
            end
         end
      end
   end

   // command gating for front and rear ports
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_front_accept <= 1'b0;
         o_front_reject <= 1'b0;
         o_rear_accept  <= 1'b0;
      end else begin
         // front: subset only; reads always, writes only when nobody else controls
         o_front_accept <= i_front_cmd && i_front_in_subset && (!i_front_is_write
                           || owner_r == rim_pkg::RIM_OWN_NONE
                           || owner_r == rim_pkg::RIM_OWN_FRONT);
         o_front_reject <= i_front_cmd && (!i_front_in_subset || (i_front_is_write
                           && owner_r != rim_pkg::RIM_OWN_NONE
                           && owner_r != rim_pkg::RIM_OWN_FRONT));
         // rear: full set, master commands too unless the unit is a slave
         o_rear_accept  <= i_rear_cmd && (!i_rear_is_master || !i_is_slave);
      end
   end

   // timeout outputs and dc output action
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_timeout    <= 1'b0;
         o_dc_off_req <= 1'b0;
      end else begin
         o_timeout    <= expire;
         o_dc_off_req <= expire && i_dc_on && !i_keep_on_after_remote;
      end
   end

   // network connection timeout, independent of the monitor
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         net_cnt_r     <= '0;
         net_up_r      <= 1'b0;
         o_net_timeout <= 1'b0;
      end else begin
         o_net_timeout <= 1'b0;
         if (i_msg_net) begin
            net_cnt_r <= '0;
            net_up_r  <= 1'b1;
         end else if (net_up_r && tick && i_net_timeout != rim_pkg::RIM_TMO_ZERO) begin
            if (net_cnt_r + rim_pkg::RIM_TMO_ONE >= i_net_timeout) begin
               net_cnt_r     <= '0;
               net_up_r      <= 1'b0;
               o_net_timeout <= 1'b1;
            end else begin
               net_cnt_r <= net_cnt_r + 1'b1;
            end
         end
      end
   end

   // link pins are asynchronous: two-stage synchronisers
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         link_s1_r <= 1'b0;
         link_s2_r <= 1'b0;
         hb_s1_r   <= 1'b0;
         hb_s2_r   <= 1'b0;
         hb_d_r    <= 1'b0;
      end else begin
         link_s1_r <= i_ms_link_ok;
         link_s2_r <= link_s1_r;
         hb_s1_r   <= i_ms_heartbeat;
         hb_s2_r   <= hb_s1_r;
         hb_d_r    <= hb_s2_r;
      end
   end

   // link watch: loss of link or heartbeat while running raises the alarm;
   // alarm is sticky until acknowledged, a new fault wins over the ack
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ms_cnt_r    <= '0;
         o_msp_alarm <= 1'b0;
      end else begin
         if (!i_ms_running || hb_s2_r != hb_d_r) begin
            ms_cnt_r <= '0;
         end else if (tick && ms_cnt_r != rim_pkg::RIM_MS_TMO_DEF) begin
            ms_cnt_r <= ms_cnt_r + 1'b1;
         end
         if (i_ms_running && (!link_s2_r || ms_cnt_r == rim_pkg::RIM_MS_TMO_DEF)) begin
            o_msp_alarm <= 1'b1;
         end else if (i_alarm_ack) begin
            o_msp_alarm <= 1'b0;
         end
      end
   end

   // registered owner view
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_owner  <= rim_pkg::RIM_OWN_NONE;
         o_remote <= 1'b0;
      end else begin
         o_owner  <= owner_r;
         o_remote <= (owner_r != rim_pkg::RIM_OWN_NONE);
      end
   end

   // expiry drops remote control on the next edge
   leave_remote_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      expire |=> owner_r == rim_pkg::RIM_OWN_NONE)
      else $error("remote kept after timeout");
   // dc off follows expiry only when setting says off
   dc_action_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      o_dc_off_req |-> $past(expire) && $past(i_dc_on) && !$past(i_keep_on_after_remote))
      else $error("dc off without cause");
   // counter cleared while idle
   idle_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      !mon_active |=> cnt_r == '0)
      else $error("counter not cleared while idle");
   // slave never expires
   slave_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_is_slave |-> !expire)
      else $error("slave monitor expired");
   // message restarts period
   msg_restart_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      mon_active && sup_msg |=> cnt_r == '0)
      else $error("message did not restart period");
   // period held while running
   period_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      mon_active && $past(mon_active) && !$past(expire) |-> $stable(period_r))
      else $error("period changed mid-run");
   // front write rejected under master control
   front_reject_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_front_cmd && i_front_is_write && owner_r == rim_pkg::RIM_OWN_MASTER
      |=> o_front_reject && !o_front_accept)
      else $error("front write not rejected");
   // front subset read always answered
   front_read_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_front_cmd && !i_front_is_write && i_front_in_subset |=> o_front_accept)
      else $error("front read refused");
   // link loss raises alarm
   msp_raise_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_ms_running && !link_s2_r |=> o_msp_alarm)
      else $error("link loss without alarm");
endmodule : rim_monitor
`default_nettype wire

// ### logic/rim_pkg.sv
// package: constants and types for the remote interface monitor
`default_nettype none
package rim_pkg;
   // interface codes for the current remote owner
   typedef enum logic [2:0] {
      RIM_OWN_NONE,
      RIM_OWN_REAR,
      RIM_OWN_FRONT,
      RIM_OWN_NET,
      RIM_OWN_ANALOG,
      RIM_OWN_MASTER
   } rim_owner_t;

   localparam int RIM_TMO_W     = 16;       // width of timeout settings, in ticks
   localparam int RIM_CLK_HZ    = 10000000; // clock rate
   localparam int RIM_TICK_MS   = 1;        // monitor tick period, in ms
   localparam int RIM_TICK_CYC  = (RIM_CLK_HZ / 1000) * RIM_TICK_MS;
   localparam int RIM_TICK_W    = 14;
   localparam logic [RIM_TMO_W-1:0] RIM_TMO_ZERO = 16'h0000;
   localparam logic [RIM_TMO_W-1:0] RIM_TMO_ONE  = 16'h0001;
   localparam logic [RIM_TMO_W-1:0] RIM_MS_TMO_DEF = 16'h0064; // 100 ticks heartbeat loss
endpackage : rim_pkg
`default_nettype wire

// ### tb/remote_interface_monitor_tb.sv
// bench for the remote interface monitor
`default_nettype none
module remote_interface_monitor_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TC = 4; // short tick keeps the run brief
   logic i_mclk, i_rst_b, i_mon_enable, i_keep_on_after_remote, i_is_slave, i_ms_running;
   logic i_req_valid, i_release, i_msg_rear, i_msg_front, i_msg_net, i_msg_master;
   logic i_front_cmd, i_front_is_write, i_front_in_subset, i_rear_cmd, i_rear_is_master;
   logic i_ms_link_ok, i_ms_heartbeat, i_alarm_ack, i_dc_on, h_en, h_front, h_msg;
   logic [15:0] i_mon_timeout, i_net_timeout;
   logic [7:0]  h_gap;
   rim_pkg::rim_owner_t i_req_src, o_owner;
   logic o_remote, o_req_error, o_front_accept, o_front_reject, o_rear_accept, o_timeout;
   logic o_dc_off_req, o_net_timeout, o_msp_alarm;
   int n_mismatch = 0, compares = 0, seed = 32'hdac8b22e, n, t;

   // host messages land on the rear or the front port
   assign i_msg_rear  = h_msg & ~h_front;
   assign i_msg_front = h_msg & h_front;

   rim_monitor #(.TICK_CYC(TC)) rim_monitor_inst (.i_mclk, .i_rst_b, .i_mon_enable,
      .i_mon_timeout, .i_net_timeout, .i_keep_on_after_remote, .i_is_slave, .i_ms_running,
      .i_req_valid, .i_req_src, .i_release, .i_msg_rear, .i_msg_front, .i_msg_net,
      .i_msg_master, .i_front_cmd, .i_front_is_write, .i_front_in_subset, .i_rear_cmd,
      .i_rear_is_master, .i_ms_link_ok, .i_ms_heartbeat, .i_alarm_ack, .i_dc_on, .o_remote,
      .o_owner, .o_req_error, .o_front_accept, .o_front_reject, .o_rear_accept, .o_timeout,
      .o_dc_off_req, .o_net_timeout, .o_msp_alarm);
   rim_host rim_host_inst (.i_mclk, .i_rst_b, .i_en(h_en), .i_gap(h_gap), .o_msg(h_msg));

   initial begin
      i_mclk = 1'b0;
      forever #50 i_mclk = ~i_mclk;
   end
   // link heartbeat keeps toggling so only the link level matters
   always @(posedge i_mclk) i_ms_heartbeat <= ~i_ms_heartbeat;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_of_test();
      $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test
   // inputs move 10 ns after the edge, outputs are read there too
   task automatic tick(input int k);
      repeat (k) @(posedge i_mclk);
      #10;
   endtask : tick
   // the error pulse stands only in the cycle after the sampling edge
   task automatic req(input rim_pkg::rim_owner_t s, input logic err);
      i_req_valid = 1'b1;
      i_req_src = s;
      tick(1);
      i_req_valid = 1'b0;
      chk(16'(o_req_error), 16'(err));
      tick(2);
   endtask : req
   task automatic rear(input logic acc);
      {i_rear_cmd, i_rear_is_master} = 2'b11;
      tick(1);
      i_rear_cmd = 1'b0;
      chk(16'(o_rear_accept), 16'(acc));
      tick(1);
   endtask : rear
   task automatic rel();
      i_release = 1'b1;
      tick(1);
      i_release = 1'b0;
      tick(3);
   endtask : rel
   task automatic front(input logic wr, input logic sub, input logic acc);
      {i_front_cmd, i_front_is_write, i_front_in_subset} = {1'b1, wr, sub};
      tick(1);
      i_front_cmd = 1'b0;
      chk(16'({o_front_accept, o_front_reject}), 16'({acc, ~acc}));
      tick(1);
   endtask : front
   // bounded wait for a pulse: 0 timeout, 1 alarm, 2 network
   task automatic wait_for(input int which, input int lim);
      n = 0;
      while (!(which == 0 ? o_timeout === 1'b1 : which == 1 ? o_msp_alarm === 1'b1
            : o_net_timeout === 1'b1)) begin
         tick(1);
         n++;
         if (n > lim) begin
            chk(16'(n), 16'(lim));
            end_of_test();
         end
      end
   endtask : wait_for
   task automatic quiet(input int c);
      t = 0;
      repeat (c) begin
         tick(1);
         if (o_timeout !== 1'b0) t++;
      end
      chk(16'(t), 16'h0000);
   endtask : quiet
   // session left to lapse; a larger period written mid-run must not apply yet
   task automatic expire(input logic keep, input logic dc);
      t = 3 + ($random(seed) & 7);
      i_mon_timeout = 16'(t);
      {i_keep_on_after_remote, i_dc_on} = {keep, dc};
      tick(2);
      req(rim_pkg::RIM_OWN_REAR, 1'b0);
      chk(16'({o_remote, o_owner}), 16'({1'b1, rim_pkg::RIM_OWN_REAR}));
      i_mon_timeout = 16'h00FF;
      wait_for(0, (t + 2) * TC);
      chk(16'(n >= (t - 2) * TC), 16'h0001);
      chk(16'(o_dc_off_req), 16'(dc & ~keep));
      tick(2);
      chk(16'({o_remote, o_owner}), 16'h0000);
   endtask : expire

   initial begin
      {i_rst_b, i_mon_enable, i_keep_on_after_remote, i_is_slave, i_ms_running} = 5'h00;
      {i_req_valid, i_release, i_msg_net, i_msg_master, i_front_cmd} = 5'h00;
      {i_front_is_write, i_front_in_subset, i_rear_cmd, i_rear_is_master} = 4'h0;
      {i_ms_link_ok, i_ms_heartbeat, i_alarm_ack, i_dc_on, h_en, h_front} = 6'h20;
      i_req_src = rim_pkg::RIM_OWN_NONE;
      {i_mon_timeout, i_net_timeout, h_gap} = 40'h0;
      tick(3);
      chk(16'({o_remote, o_owner, o_timeout, o_msp_alarm}), 16'h0000);
      {i_rst_b, i_mon_enable} = 2'b11;
      tick(1);
      req(rim_pkg::RIM_OWN_REAR, 1'b0);
      front(1'b0, 1'b1, 1'b1);
      front(1'b1, 1'b1, 1'b0);
      rear(1'b1);
      rel();
      front(1'b1, 1'b1, 1'b1);
      front(1'b1, 1'b0, 1'b0);
      $display("test access done");
      for (int i = 0; i < 4; i++) expire(i[0], i[1]);
      $display("test expiry done");
      i_mon_timeout = 16'h0008;
      h_gap = 8'(5 + ($random(seed) & 15));
      h_en = 1'b1;
      tick(2);
      req(rim_pkg::RIM_OWN_REAR, 1'b0);
      quiet(200);
      h_front = 1'b1;
      wait_for(0, 8 * TC + 10);
      {h_en, h_front} = 2'b00;
      tick(3);
      $display("test keep-alive done");
      i_is_slave = 1'b1;
      req(rim_pkg::RIM_OWN_REAR, 1'b0);
      quiet(60);
      rear(1'b0);
      rel();
      {i_is_slave, i_mon_enable} = 2'b00;
      req(rim_pkg::RIM_OWN_REAR, 1'b0);
      quiet(60);
      rel();
      i_mon_enable = 1'b1;
      $display("test inactive monitor done");
      i_ms_running = 1'b1;
      req(rim_pkg::RIM_OWN_REAR, 1'b1);
      i_ms_running = 1'b0;
      req(rim_pkg::RIM_OWN_MASTER, 1'b0);
      req(rim_pkg::RIM_OWN_FRONT, 1'b1);
      front(1'b1, 1'b1, 1'b0);
      front(1'b0, 1'b1, 1'b1);
      rel();
      req(rim_pkg::RIM_OWN_REAR, 1'b0);
      req(rim_pkg::RIM_OWN_MASTER, 1'b1);
      rel();
      $display("test refusals done");
      // the link is only watched while master-slave runs
      i_ms_running = 1'b1;
      i_ms_link_ok = 1'b0;
      wait_for(1, 10);
      i_ms_link_ok = 1'b1;
      tick(4);
      i_alarm_ack = 1'b1;
      tick(1);
      i_alarm_ack = 1'b0;
      tick(2);
      chk(16'(o_msp_alarm), 16'h0000);
      i_ms_running = 1'b0;
      $display("test link alarm done");
      i_net_timeout = 16'h0005;
      // one network message arms the connection timeout
      i_msg_net = 1'b1;
      tick(1);
      i_msg_net = 1'b0;
      req(rim_pkg::RIM_OWN_REAR, 1'b0);
      wait_for(2, 7 * TC + 10);
      wait_for(0, 8 * TC + 10);
      $display("test network timeout done");
      end_of_test();
   end
endmodule : remote_interface_monitor_tb
`default_nettype wire

// ### tb/rim_host.sv
// host model: keep-alive messages at a set spacing
`default_nettype none
module rim_host (
   input  wire logic       i_mclk,
   input  wire logic       i_rst_b,
   input  wire logic       i_en,
   input  wire logic [7:0] i_gap,
   output logic            o_msg
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt_r;
   // a gap below the period keeps control alive, a stall lets it lapse
   always @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_r <= 8'h00;
         o_msg <= 1'b0;
      end else begin
         cnt_r <= (cnt_r >= i_gap) ? 8'h00 : cnt_r + 8'h01;
         o_msg <= i_en && (cnt_r >= i_gap);
      end
   end
endmodule : rim_host
`default_nettype wire
